// File: common/spmux_pkg.sv
// shared constants and carrier types of the serial-control pin multiplexer
package spmux_pkg;
    // pin slots of the multiplexed group
    localparam int PIN_COUNT = 4;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_FS = 2;
    localparam int PIN_SCK = 3;

    // register byte offsets on the bus
    localparam int ADDR_WIDTH = 8;
    localparam logic [7:0] OFFS_PORT_DATA = 8'h00;
    localparam logic [7:0] OFFS_PORT_DIRECTION = 8'h04;
    localparam logic [7:0] OFFS_PORT_FUNCTION_SELECT = 8'h08;
    localparam logic [7:0] OFFS_SERIAL_CONFIG = 8'h0C;
    localparam logic [7:0] OFFS_PIN_STATUS = 8'h10;

    // serial configuration fields
    localparam int CFG_WIDTH = 7;
    localparam int CFG_SYNC_MODE = 0;
    localparam int CFG_A_OUT = 1;
    localparam int CFG_A_FLAG = 2;
    localparam int CFG_B_OUT = 3;
    localparam int CFG_B_FLAG = 4;
    localparam int CFG_FS_OUT = 5;
    localparam int CFG_SCK_OUT = 6;

    // pin status fields
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_SERIAL_LSB = 8;

    // reset values: every pin general-purpose input
    localparam logic [3:0] PORT_DATA_RESET = 4'h0;
    localparam logic [3:0] PORT_DIRECTION_RESET = 4'h0;
    localparam logic [3:0] PORT_FUNCTION_RESET = 4'h0;
    localparam logic [6:0] SERIAL_CONFIG_RESET = 7'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // values offered by the serial port core
    typedef struct packed {
        logic tx1Data;
        logic tx2Data;
        logic flag0Out;
        logic flag1Out;
        logic rxClockOut;
        logic rxFrameSyncOut;
        logic frameSyncOut;
        logic bitClockOut;
    } spmux_core_drive_type;

    // values handed to the serial port core
    typedef struct packed {
        logic syncMode;
        logic rxBitClock;
        logic rxClockRise;
        logic txBitClock;
        logic txClockRise;
        logic rxFrameSync;
        logic txFrameSync;
        logic flag0In;
        logic flag1In;
    } spmux_core_sense_type;
endpackage

// File: logic/spmux_serial_pin_mux.sv
// pin multiplexer for the control pins of the first synchronous serial port
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module spmux_serial_pin_mux #(
    parameter int ADDR_WIDTH = spmux_pkg::ADDR_WIDTH
) (
    input logic ref_clk,
    input logic reset_n,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [ADDR_WIDTH-1:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic serialCtrlPinAIn,
    output logic serialCtrlPinAOut,
    output logic serialCtrlPinAOeN,
    input logic serialCtrlPinBIn,
    output logic serialCtrlPinBOut,
    output logic serialCtrlPinBOeN,
    input logic serialCtrlPinFrameSyncIn,
    output logic serialCtrlPinFrameSyncOut,
    output logic serialCtrlPinFrameSyncOeN,
    input logic serialBitClockPinIn,
    output logic serialBitClockPinOut,
    output logic serialBitClockPinOeN,
    input spmux_pkg::spmux_core_drive_type coreDrive,
    output spmux_pkg::spmux_core_sense_type coreSense
);
    localparam int NP = spmux_pkg::PIN_COUNT;

    logic [1:0] resetSync_reg;
    logic rstN;
    logic [NP-1:0] pinRaw;
    logic [NP-1:0] pinLevel;
    logic [NP-1:0] pinPrev;
    logic [NP-1:0] pinRise;
    logic [3:0] portData_reg;
    logic [3:0] portDirection_reg;
    logic [3:0] portFunctionSelect_reg;
    logic [spmux_pkg::CFG_WIDTH-1:0] serialConfig_reg;
    logic [NP-1:0] pinOut_reg;
    logic [NP-1:0] pinOeN_reg;
    logic [NP-1:0] pinOut_next;
    logic [NP-1:0] pinOeN_next;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    spmux_pkg::spmux_core_sense_type coreSense_reg;
    spmux_pkg::spmux_core_sense_type coreSense_next;
    logic syncMode;
    logic accessStart;
    logic writeCommit;

    function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] addr);
        isMapped = (addr == spmux_pkg::OFFS_PORT_DATA)
            || (addr == spmux_pkg::OFFS_PORT_DIRECTION)
            || (addr == spmux_pkg::OFFS_PORT_FUNCTION_SELECT)
            || (addr == spmux_pkg::OFFS_SERIAL_CONFIG)
            || (addr == spmux_pkg::OFFS_PIN_STATUS);
    endfunction

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            resetSync_reg <= 2'b00;
        end else begin
            resetSync_reg <= {resetSync_reg[0], 1'b1};
        end
    end
    assign rstN = resetSync_reg[1];

    // pin inputs: two sync stages, a third only for edge finding
    assign pinRaw = {serialBitClockPinIn, serialCtrlPinFrameSyncIn,
                     serialCtrlPinBIn, serialCtrlPinAIn};
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_pin_sync
            logic [2:0] stage_reg;
            always_ff @(posedge ref_clk or negedge rstN) begin
                if (!rstN) begin
                    stage_reg <= 3'b000;
                end else begin
                    stage_reg <= {stage_reg[1:0], pinRaw[gi]};
                end
            end
            assign pinLevel[gi] = stage_reg[1];
            assign pinPrev[gi] = stage_reg[2];
            assign pinRise[gi] = pinLevel[gi] & ~pinPrev[gi];
        end
    endgenerate

    // bus slave: one wait cycle, answer registered
    assign accessStart = psel & penable & ~pready_reg;
    assign writeCommit = psel & penable & pready_reg & pwrite & pstrb[0];

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= accessStart;
            pslverr_reg <= accessStart & ~isMapped(paddr);
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            prdata_reg <= spmux_pkg::READ_ZERO;
        end else if (accessStart && !pwrite) begin
            prdata_reg <= spmux_pkg::READ_ZERO;
            case (paddr)
                spmux_pkg::OFFS_PORT_DATA: begin
                    prdata_reg[3:0] <= portData_reg;
                end
                spmux_pkg::OFFS_PORT_DIRECTION: begin
                    prdata_reg[3:0] <= portDirection_reg;
                end
                spmux_pkg::OFFS_PORT_FUNCTION_SELECT: begin
                    prdata_reg[3:0] <= portFunctionSelect_reg;
                end
                spmux_pkg::OFFS_SERIAL_CONFIG: begin
                    prdata_reg[spmux_pkg::CFG_WIDTH-1:0] <= serialConfig_reg;
                end
                spmux_pkg::OFFS_PIN_STATUS: begin
                    prdata_reg[spmux_pkg::STAT_LEVEL_LSB +: NP] <= pinLevel;
                    prdata_reg[spmux_pkg::STAT_SERIAL_LSB +: NP] <= portFunctionSelect_reg;
                end
                default: begin
                    prdata_reg <= spmux_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // writes land only on the edge that completes the access
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            portData_reg <= spmux_pkg::PORT_DATA_RESET;
            portDirection_reg <= spmux_pkg::PORT_DIRECTION_RESET;
            portFunctionSelect_reg <= spmux_pkg::PORT_FUNCTION_RESET;
            serialConfig_reg <= spmux_pkg::SERIAL_CONFIG_RESET;
        end else if (writeCommit) begin
            case (paddr)
                spmux_pkg::OFFS_PORT_DATA: begin
                    portData_reg <= pwdata[3:0];
                end
                spmux_pkg::OFFS_PORT_DIRECTION: begin
                    portDirection_reg <= pwdata[3:0];
                end
                spmux_pkg::OFFS_PORT_FUNCTION_SELECT: begin
                    portFunctionSelect_reg <= pwdata[3:0];
                end
                spmux_pkg::OFFS_SERIAL_CONFIG: begin
                    serialConfig_reg <= pwdata[spmux_pkg::CFG_WIDTH-1:0];
                end
                default: begin
                    portData_reg <= portData_reg;
                end
            endcase
        end
    end

    assign syncMode = serialConfig_reg[spmux_pkg::CFG_SYNC_MODE];

    // pin drive selection; enables are active low
    always_comb begin
        pinOut_next = portData_reg;
        pinOeN_next = ~portDirection_reg;
        if (portFunctionSelect_reg[spmux_pkg::PIN_A]) begin
            if (!syncMode) begin
                pinOeN_next[spmux_pkg::PIN_A] = ~serialConfig_reg[spmux_pkg::CFG_A_OUT];
                pinOut_next[spmux_pkg::PIN_A] = coreDrive.rxClockOut;
            end else if (serialConfig_reg[spmux_pkg::CFG_A_FLAG]) begin
                pinOeN_next[spmux_pkg::PIN_A] = ~serialConfig_reg[spmux_pkg::CFG_A_OUT];
                pinOut_next[spmux_pkg::PIN_A] = coreDrive.flag0Out;
            end else begin
                pinOeN_next[spmux_pkg::PIN_A] = 1'b0;
                pinOut_next[spmux_pkg::PIN_A] = coreDrive.tx1Data;
            end
        end
        if (portFunctionSelect_reg[spmux_pkg::PIN_B]) begin
            if (!syncMode) begin
                pinOeN_next[spmux_pkg::PIN_B] = ~serialConfig_reg[spmux_pkg::CFG_B_OUT];
                pinOut_next[spmux_pkg::PIN_B] = coreDrive.rxFrameSyncOut;
            end else if (serialConfig_reg[spmux_pkg::CFG_B_FLAG]) begin
                pinOeN_next[spmux_pkg::PIN_B] = ~serialConfig_reg[spmux_pkg::CFG_B_OUT];
                pinOut_next[spmux_pkg::PIN_B] = coreDrive.flag1Out;
            end else begin
                pinOeN_next[spmux_pkg::PIN_B] = 1'b0;
                pinOut_next[spmux_pkg::PIN_B] = coreDrive.tx2Data;
            end
        end
        if (portFunctionSelect_reg[spmux_pkg::PIN_FS]) begin
            pinOeN_next[spmux_pkg::PIN_FS] = ~serialConfig_reg[spmux_pkg::CFG_FS_OUT];
            pinOut_next[spmux_pkg::PIN_FS] = coreDrive.frameSyncOut;
        end
        if (portFunctionSelect_reg[spmux_pkg::PIN_SCK]) begin
            pinOeN_next[spmux_pkg::PIN_SCK] = ~serialConfig_reg[spmux_pkg::CFG_SCK_OUT];
            pinOut_next[spmux_pkg::PIN_SCK] = coreDrive.bitClockOut;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pinOut_reg <= {NP{1'b0}};
            pinOeN_reg <= {NP{1'b1}};
        end else begin
            pinOut_reg <= pinOut_next;
            pinOeN_reg <= pinOeN_next;
        end
    end

    // serial-side view of the pins; a GPIO pin is cut off from the core
    always_comb begin
        coreSense_next = '0;
        coreSense_next.syncMode = syncMode;
        if (portFunctionSelect_reg[spmux_pkg::PIN_SCK]) begin
            coreSense_next.txBitClock = pinLevel[spmux_pkg::PIN_SCK];
            coreSense_next.txClockRise = pinRise[spmux_pkg::PIN_SCK];
            if (syncMode) begin
                coreSense_next.rxBitClock = pinLevel[spmux_pkg::PIN_SCK];
                coreSense_next.rxClockRise = pinRise[spmux_pkg::PIN_SCK];
            end
        end
        if (!syncMode && portFunctionSelect_reg[spmux_pkg::PIN_A]) begin
            coreSense_next.rxBitClock = pinLevel[spmux_pkg::PIN_A];
            coreSense_next.rxClockRise = pinRise[spmux_pkg::PIN_A];
        end
        if (syncMode && portFunctionSelect_reg[spmux_pkg::PIN_A]
                && serialConfig_reg[spmux_pkg::CFG_A_FLAG]) begin
            coreSense_next.flag0In = pinLevel[spmux_pkg::PIN_A];
        end
        if (syncMode && portFunctionSelect_reg[spmux_pkg::PIN_B]
                && serialConfig_reg[spmux_pkg::CFG_B_FLAG]) begin
            coreSense_next.flag1In = pinLevel[spmux_pkg::PIN_B];
        end
        if (portFunctionSelect_reg[spmux_pkg::PIN_FS]) begin
            // an output frame sync loops back from the core, not the slow pin path
            coreSense_next.txFrameSync = serialConfig_reg[spmux_pkg::CFG_FS_OUT]
                ? coreDrive.frameSyncOut : pinLevel[spmux_pkg::PIN_FS];
            if (syncMode) begin
                coreSense_next.rxFrameSync = coreSense_next.txFrameSync;
            end
        end
        if (!syncMode && portFunctionSelect_reg[spmux_pkg::PIN_B]) begin
            coreSense_next.rxFrameSync = serialConfig_reg[spmux_pkg::CFG_B_OUT]
                ? coreDrive.rxFrameSyncOut : pinLevel[spmux_pkg::PIN_B];
        end
    end

    // holds on the far side: six cycles per clock half keep edges visible
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            coreSense_reg <= '0;
        end else begin
            coreSense_reg <= coreSense_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign serialCtrlPinAOut = pinOut_reg[spmux_pkg::PIN_A];
    assign serialCtrlPinAOeN = pinOeN_reg[spmux_pkg::PIN_A];
    assign serialCtrlPinBOut = pinOut_reg[spmux_pkg::PIN_B];
    assign serialCtrlPinBOeN = pinOeN_reg[spmux_pkg::PIN_B];
    assign serialCtrlPinFrameSyncOut = pinOut_reg[spmux_pkg::PIN_FS];
    assign serialCtrlPinFrameSyncOeN = pinOeN_reg[spmux_pkg::PIN_FS];
    assign serialBitClockPinOut = pinOut_reg[spmux_pkg::PIN_SCK];
    assign serialBitClockPinOeN = pinOeN_reg[spmux_pkg::PIN_SCK];
    assign coreSense = coreSense_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    sequence seqFuncWrite;
        psel && penable && pready_reg && pwrite && pstrb[0]
            && paddr == spmux_pkg::OFFS_PORT_FUNCTION_SELECT;
    endsequence

    AST_RESET_GPIO: assert property ($rose(rstN) |-> pinOeN_reg == {NP{1'b1}}
        && portFunctionSelect_reg == spmux_pkg::PORT_FUNCTION_RESET)
        else $error("pins not general-purpose inputs after reset");
    AST_GPIO_DIRECTION: assert property (!portFunctionSelect_reg[spmux_pkg::PIN_FS]
        |=> pinOeN_reg[spmux_pkg::PIN_FS] == !$past(portDirection_reg[spmux_pkg::PIN_FS]))
        else $error("gpio frame sync pin ignores direction bit");
    AST_FUNC_SELECT: assert property (seqFuncWrite ##1 1'b1
        |-> portFunctionSelect_reg == $past(pwdata[3:0]))
        else $error("function select write not applied");
    AST_ASYNC_RX_CLOCK: assert property (!syncMode && portFunctionSelect_reg[spmux_pkg::PIN_A]
        ##2 (pinRise[spmux_pkg::PIN_A] && !syncMode && portFunctionSelect_reg[spmux_pkg::PIN_A])
        |=> coreSense_reg.rxClockRise)
        else $error("async receive clock edge lost");
    AST_SYNC_TX1: assert property (syncMode && portFunctionSelect_reg[spmux_pkg::PIN_A]
        && !serialConfig_reg[spmux_pkg::CFG_A_FLAG]
        |=> !pinOeN_reg[spmux_pkg::PIN_A] && pinOut_reg[spmux_pkg::PIN_A] == $past(coreDrive.tx1Data))
        else $error("transmitter 1 not on pin a");
    AST_SYNC_TX2: assert property (syncMode && portFunctionSelect_reg[spmux_pkg::PIN_B]
        && !serialConfig_reg[spmux_pkg::CFG_B_FLAG]
        |=> !pinOeN_reg[spmux_pkg::PIN_B] && pinOut_reg[spmux_pkg::PIN_B] == $past(coreDrive.tx2Data))
        else $error("transmitter 2 not on pin b");
    AST_FS_DRIVE: assert property (portFunctionSelect_reg[spmux_pkg::PIN_FS]
        && serialConfig_reg[spmux_pkg::CFG_FS_OUT]
        |=> !pinOeN_reg[spmux_pkg::PIN_FS]
        && pinOut_reg[spmux_pkg::PIN_FS] == $past(coreDrive.frameSyncOut))
        else $error("internal frame sync not driven");
    AST_FS_SHARED: assert property (syncMode && portFunctionSelect_reg[spmux_pkg::PIN_FS]
        |=> coreSense_reg.rxFrameSync == coreSense_reg.txFrameSync)
        else $error("sync receiver frame sync differs from transmitter");
    AST_SERIAL_NO_DIR: assert property (portFunctionSelect_reg[spmux_pkg::PIN_SCK]
        && !serialConfig_reg[spmux_pkg::CFG_SCK_OUT] |=> pinOeN_reg[spmux_pkg::PIN_SCK])
        else $error("direction bit drives serial bit clock pin");
endmodule

// File: sim/spmux_far_end.sv
// behavioural far-side serial peer: static pin levels plus a bursty bit clock on slot 3
`timescale 1ns/10ps
module spmux_far_end (
    input wire logic [3:0] drvEn,
    input wire logic [3:0] drvVal,
    input wire logic runClk,
    output logic [3:0] lvl
);
    logic clkReg = 1'b0;
    logic [3:0] held = 4'h0;
    logic [3:0] drive;

    // clock only inside a burst, stands low between them; half period 24 ns = 6 ref cycles
    always @(posedge runClk) begin
        #3;
        while (runClk) begin
            #24 clkReg = 1'b1;
            #24 clkReg = 1'b0;
        end
    end
    assign drive = drvVal | {clkReg, 3'h0};
    // released lines carry no pull: show the inverse of the last driven level
    always @(drvEn or drive) begin
        for (int i = 0; i < 4; i++) begin
            if (drvEn[i]) begin
                lvl[i] = drive[i];
                held[i] = drive[i];
            end else begin
                lvl[i] = ~held[i];
            end
        end
    end
endmodule

// File: sim/spmux_serial_pin_mux_tb.sv
// self-checking bench for the serial-control pin multiplexer
`timescale 1ns/10ps
module spmux_serial_pin_mux_tb;
    typedef struct packed {
        logic [3:0] fsel, dir, dat;
        logic [6:0] cfg;
        logic [7:0] drv;
        logic [3:0] pEn, pVal, eOeN, eOut;
        logic [7:0] eSense;
    } spmux_row_type;

    logic ref_clk, reset_n, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, pEn, pVal, oeN, outs, ptrLvl, pinLvl;
    logic pready, pslverr, err, runClk;
    spmux_pkg::spmux_core_drive_type coreDrive;
    spmux_pkg::spmux_core_sense_type coreSense;
    int failures, n_compared, cycles, txRises, rxRises;
    spmux_row_type rows [11];

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // wire level: the mux when it drives, the far side otherwise
    assign pinLvl = (~oeN & outs) | (oeN & ptrLvl);

    spmux_serial_pin_mux i_spmux_serial_pin_mux (.ref_clk(ref_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serialCtrlPinAIn(pinLvl[0]), .serialCtrlPinAOut(outs[0]),
        .serialCtrlPinAOeN(oeN[0]), .serialCtrlPinBIn(pinLvl[1]),
        .serialCtrlPinBOut(outs[1]), .serialCtrlPinBOeN(oeN[1]),
        .serialCtrlPinFrameSyncIn(pinLvl[2]), .serialCtrlPinFrameSyncOut(outs[2]),
        .serialCtrlPinFrameSyncOeN(oeN[2]), .serialBitClockPinIn(pinLvl[3]),
        .serialBitClockPinOut(outs[3]), .serialBitClockPinOeN(oeN[3]),
        .coreDrive(coreDrive), .coreSense(coreSense));
    spmux_far_end i_spmux_far_end (.drvEn(pEn), .drvVal(pVal), .runClk(runClk), .lvl(ptrLvl));

    always @(posedge ref_clk) begin
        cycles++;
        if (coreSense.txClockRise === 1'b1) txRises++;
        if (coreSense.rxClockRise === 1'b1) rxRises++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // no own limit: the cycle ceiling ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (!(pready === 1'b1 && penable === 1'b1));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        rows = '{
            '{4'h0, 4'hF, 4'h5, 7'h00, 8'h00, 4'h0, 4'h0, 4'h0, 4'h5, 8'h00},
            '{4'h0, 4'h0, 4'hF, 7'h00, 8'h00, 4'hF, 4'hA, 4'hF, 4'h0, 8'h00},
            '{4'h0, 4'hA, 4'hF, 7'h00, 8'h00, 4'h5, 4'h1, 4'h5, 4'hA, 8'h00},
            '{4'h7, 4'h0, 4'h0, 7'h2A, 8'h06, 4'h8, 4'h0, 4'h8, 4'h6, 8'h0C},
            '{4'hF, 4'hF, 4'h0, 7'h00, 8'h00, 4'hF, 4'h7, 4'hF, 4'h0, 8'h8C},
            '{4'h3, 4'h0, 4'h0, 7'h01, 8'h80, 4'hC, 4'h0, 4'hC, 4'h1, 8'h00},
            '{4'h3, 4'h0, 4'h0, 7'h1F, 8'h90, 4'hC, 4'h0, 4'hC, 4'h2, 8'h01},
            '{4'h3, 4'h0, 4'h0, 7'h15, 8'h00, 4'hF, 4'h1, 4'hF, 4'h0, 8'h02},
            '{4'hC, 4'h0, 4'h0, 7'h01, 8'h00, 4'hF, 4'hC, 4'hF, 4'h0, 8'hAC},
            '{4'hC, 4'h0, 4'h0, 7'h00, 8'h00, 4'hF, 4'hC, 4'hF, 4'h0, 8'h24},
            '{4'hC, 4'h0, 4'h0, 7'h61, 8'h02, 4'h3, 4'h0, 4'h3, 4'h4, 8'h0C}};
        {psel, penable, pwrite, runClk} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        coreDrive = 8'h00;
        {pEn, pVal} = 8'hF0;
        {failures, n_compared, cycles, txRises, rxRises} = '0;
        reset_n = 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("reset oen", {28'h0, oeN}, 32'h0000_000F);
        check("reset sense", {23'h0, coreSense}, 32'h0000_0000);
        for (int a = 0; a < 16; a += 4) begin
            apb(a[7:0], 1'b0, 32'h0000_0000);
            check("reset reg", rd, 32'h0000_0000);
            check("reset reg err", {31'h0, err}, 32'h0000_0000);
        end
        $display("test reset done");

        foreach (rows[i]) begin
            pEn <= rows[i].pEn;
            pVal <= rows[i].pVal;
            coreDrive <= rows[i].drv;
            apb(spmux_pkg::OFFS_PORT_DATA, 1'b1, {28'h0, rows[i].dat});
            apb(spmux_pkg::OFFS_PORT_DIRECTION, 1'b1, {28'h0, rows[i].dir});
            apb(spmux_pkg::OFFS_SERIAL_CONFIG, 1'b1, {25'h0, rows[i].cfg});
            apb(spmux_pkg::OFFS_PORT_FUNCTION_SELECT, 1'b1, {28'h0, rows[i].fsel});
            repeat (8) @(posedge ref_clk);
            check("pin oen", {28'h0, oeN}, {28'h0, rows[i].eOeN});
            check("pin out", {28'h0, outs | oeN}, {28'h0, rows[i].eOut | rows[i].eOeN});
            check("sense", {23'h0, coreSense}, {23'h0, rows[i].cfg[0], rows[i].eSense});
            apb(spmux_pkg::OFFS_PIN_STATUS, 1'b0, 32'h0000_0000);
            check("status", rd, {20'h0, rows[i].fsel, 4'h0,
                (~rows[i].eOeN & rows[i].eOut) | (rows[i].eOeN & rows[i].pVal)});
            $display("row %0d done", i);
        end

        // unmapped places: error answer on write and on read, zero read data
        apb(8'h20, 1'b1, 32'h0000_00FF);
        check("unmapped write err", {31'h0, err}, 32'h0000_0001);
        apb(8'h14, 1'b0, 32'h0000_0000);
        check("unmapped read err", {31'h0, err}, 32'h0000_0001);
        check("unmapped read data", rd, 32'h0000_0000);
        $display("test unmapped done");

        // external bit clock burst of four periods, synchronous mode
        {pEn, pVal} <= 8'hF0;
        apb(spmux_pkg::OFFS_SERIAL_CONFIG, 1'b1, 32'h0000_0001);
        apb(spmux_pkg::OFFS_PORT_FUNCTION_SELECT, 1'b1, 32'h0000_0008);
        repeat (6) @(posedge ref_clk);
        txRises = 0;
        rxRises = 0;
        runClk <= 1'b1;
        repeat (47) @(posedge ref_clk);
        runClk <= 1'b0;
        repeat (12) @(posedge ref_clk);
        check("tx clock rises", txRises, 32'h0000_0004);
        check("rx clock rises", rxRises, 32'h0000_0004);
        $display("test link clock done");

        // second reset in mid-run returns every pin to general-purpose input
        apb(spmux_pkg::OFFS_PORT_DIRECTION, 1'b1, 32'h0000_000F);
        apb(spmux_pkg::OFFS_PORT_FUNCTION_SELECT, 1'b1, 32'h0000_000F);
        repeat (2) @(posedge ref_clk);
        check("pre reset oen", {28'h0, oeN}, 32'h0000_000C);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("mid reset oen", {28'h0, oeN}, 32'h0000_000F);
        apb(spmux_pkg::OFFS_PORT_FUNCTION_SELECT, 1'b0, 32'h0000_0000);
        check("mid reset select", rd, 32'h0000_0000);
        $display("test mid reset done");
        results();
    end
endmodule
